// ===== bdr_consts.svh
// offsets, field positions, reset values and decode constants of the readback bank
`ifndef BDR_CONSTS_SVH
`define BDR_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BDR_ADDR_W 8
`define BDR_OFS_OUTPUT_DUTY 8'h18
`define BDR_OFS_LED_CURRENT 8'h1A
`define BDR_OFS_BOOST_VOLTAGE 8'h1C
`define BDR_OFS_STRAP_DETECT 8'h1E
`define BDR_RESET_VALUE 16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BDR_DAC_MSB 11
`define BDR_BOOST_MSB 10
`define BDR_LED_FREQ_LSB 12
`define BDR_LAYOUT_LSB 8
`define BDR_SWITCH_FREQ_LSB 3
`define BDR_MODE_LSB 0

// ----------------------------------------------------------------
// decode constants
// ----------------------------------------------------------------
`define BDR_ADDR_LOW_HALF 7'h2B
`define BDR_ADDR_HIGH_HALF 7'h2A
`define BDR_BOOST_BASE_MV 16'h04BA
`define BDR_BOOST_STEP_DNA 8'hBD

`endif

// ===== bdr_pkg.sv
// types shared by the readback bank and its strap decoder
package bdr_pkg;

    typedef enum logic [1:0] {
        BDR_DIM_PWM,
        BDR_DIM_HYBRID,
        BDR_DIM_CONST_CURRENT,
        BDR_DIM_DIRECT_PWM
    } bdr_dim_mode_t;

    typedef enum logic [1:0] {
        BDR_LAYOUT_SEPARATE,
        BDR_LAYOUT_THREE_GROUPS,
        BDR_LAYOUT_TWO_GROUPS,
        BDR_LAYOUT_ALL_TIED
    } bdr_layout_kind_t;

endpackage

// ===== bdr_strap_if.sv
// carrier between the readback bank and the strap decoder
`timescale 1ns/1ps
interface bdr_strap_if;
    logic [2:0] led_freq_code;
    logic [2:0] layout_code;
    logic [2:0] switch_freq_code;
    logic [2:0] mode_code;
    logic [14:0] led_freq_hz;
    logic [2:0] string_count;
    bdr_pkg::bdr_layout_kind_t layout_kind;
    logic [11:0] switch_freq_khz;
    bdr_pkg::bdr_dim_mode_t dim_mode;
    logic [6:0] bus_addr;

    modport bank (
        output led_freq_code, layout_code, switch_freq_code, mode_code,
        input led_freq_hz, string_count, layout_kind, switch_freq_khz, dim_mode, bus_addr
    );
    modport decoder (
        input led_freq_code, layout_code, switch_freq_code, mode_code,
        output led_freq_hz, string_count, layout_kind, switch_freq_khz, dim_mode, bus_addr
    );
endinterface

// ===== bdr_strap_decode.sv
// lookup of detected strap codes into frequencies, layout and bus address
`timescale 1ns/1ps
`include "bdr_consts.svh"
module bdr_strap_decode (
    bdr_strap_if.decoder strap
);

    // ----------------------------------------------------------------
    // lookups
    // ----------------------------------------------------------------
    function automatic logic [14:0] led_hz(input logic [2:0] code);
        unique case (code)
            3'h0: led_hz = 15'h0098;
            3'h1: led_hz = 15'h0131;
            3'h2: led_hz = 15'h0262;
            3'h3: led_hz = 15'h04C5;
            3'h4: led_hz = 15'h0989;
            3'h5: led_hz = 15'h1313;
            3'h6: led_hz = 15'h2626;
            3'h7: led_hz = 15'h4C4B;
        endcase
    endfunction

    function automatic logic [11:0] switch_khz(input logic [2:0] code);
        unique case (code)
            3'h0: switch_khz = 12'h064;
            3'h1: switch_khz = 12'h0C8;
            3'h2: switch_khz = 12'h12F;
            3'h3: switch_khz = 12'h190;
            3'h4: switch_khz = 12'h1F4;
            3'h5: switch_khz = 12'h71A;
            3'h6: switch_khz = 12'h7D0;
            3'h7: switch_khz = 12'h8AE;
        endcase
    endfunction

    assign strap.led_freq_hz = led_hz(strap.led_freq_code);
    assign strap.switch_freq_khz = switch_khz(strap.switch_freq_code);

    always_comb begin
        unique case (strap.layout_code)
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4: begin
                // separate strings: six down to two
                strap.string_count = 3'(3'h6 - strap.layout_code);
                strap.layout_kind = bdr_pkg::BDR_LAYOUT_SEPARATE;
            end
            3'h5: begin
                strap.string_count = 3'h3;
                strap.layout_kind = bdr_pkg::BDR_LAYOUT_THREE_GROUPS;
            end
            3'h6: begin
                strap.string_count = 3'h2;
                strap.layout_kind = bdr_pkg::BDR_LAYOUT_TWO_GROUPS;
            end
            3'h7: begin
                strap.string_count = 3'h1;
                strap.layout_kind = bdr_pkg::BDR_LAYOUT_ALL_TIED;
            end
        endcase
    end

    // upper bit picks the address half, lower two the dimming scheme
    assign strap.bus_addr = strap.mode_code[2] ? `BDR_ADDR_HIGH_HALF
                                               : `BDR_ADDR_LOW_HALF;
    assign strap.dim_mode = bdr_pkg::bdr_dim_mode_t'(strap.mode_code[1:0]);

endmodule

// ===== bdr_readback_bank.sv
// read-only diagnostic readback bank of the backlight driver
//
// Overview of operation
// - output duty readback fills all sixteen bits
// - DAC code bits 11-0, upper zero
// - boost code bits 10-0, upper zero
// - boost voltage relation from two-resistor feedback
// - LED PWM frequency code in 14-12
// - layout codes 0-4 are six..two strings
// - layout codes 5-7 are grouped outputs
// - boost switching frequency code in 5-3
// - mode code picks bus address half
// - mode order PWM, hybrid, constant, direct
// - strap register reserved bits read zero
`timescale 1ns/1ps
`include "bdr_consts.svh"
module bdr_readback_bank (
    input wire logic mclk,
    input wire logic nrst,
    // register access port of the serial interface
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic reg_addr_hit,
    // sources
    input wire logic duty_update,
    input wire logic [15:0] duty_code,
    input wire logic dac_update,
    input wire logic [11:0] sink_dac_code,
    input wire logic boost_update,
    input wire logic [10:0] boost_level_code,
    input wire logic strap_done,
    input wire logic [2:0] detected_led_freq_code,
    input wire logic [2:0] detected_string_layout,
    input wire logic [2:0] detected_switch_freq_code,
    input wire logic [2:0] detected_mode_code,
    // decoded strap results and boost step current
    output logic [14:0] led_freq_hz,
    output logic [2:0] string_count,
    output bdr_pkg::bdr_layout_kind_t layout_kind,
    output logic [11:0] switch_freq_khz,
    output bdr_pkg::bdr_dim_mode_t dim_mode,
    output logic [6:0] bus_addr,
    output logic [18:0] boost_step_dna
);

    logic [15:0] output_duty_readback_reg;
    logic [11:0] led_current_code_readback_reg;
    logic [10:0] boost_voltage_code_readback_reg;
    logic [2:0] led_freq_reg;
    logic [2:0] layout_reg;
    logic [2:0] switch_freq_reg;
    logic [2:0] mode_reg;
    logic [15:0] rd_data_next;
    logic hit_next;

    bdr_strap_if strap ();

    // ----------------------------------------------------------------
    // source capture
    // ----------------------------------------------------------------
    // host writes never reach these flops; reg_wr_data is unused on purpose
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            output_duty_readback_reg <= `BDR_RESET_VALUE;
        end else if (duty_update) begin
            output_duty_readback_reg <= duty_code;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            led_current_code_readback_reg <= 12'h000;
        end else if (dac_update) begin
            led_current_code_readback_reg <= sink_dac_code;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boost_voltage_code_readback_reg <= 11'h000;
        end else if (boost_update) begin
            boost_voltage_code_readback_reg <= boost_level_code;
        end
    end

    // all four strap results land together so a read never mixes two detections
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            led_freq_reg <= 3'h0;
            layout_reg <= 3'h0;
            switch_freq_reg <= 3'h0;
            mode_reg <= 3'h0;
        end else if (strap_done) begin
            led_freq_reg <= detected_led_freq_code;
            layout_reg <= detected_string_layout;
            switch_freq_reg <= detected_switch_freq_code;
            mode_reg <= detected_mode_code;
        end
    end

    // ----------------------------------------------------------------
    // strap decode
    // ----------------------------------------------------------------
    assign strap.led_freq_code = led_freq_reg;
    assign strap.layout_code = layout_reg;
    assign strap.switch_freq_code = switch_freq_reg;
    assign strap.mode_code = mode_reg;

    bdr_strap_decode u_decode (
        .strap(strap)
    );

    // decoded results are re-timed so every output comes straight from a flop
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            led_freq_hz <= 15'h0000;
        end else begin
            led_freq_hz <= strap.led_freq_hz;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            string_count <= 3'h0;
            layout_kind <= bdr_pkg::BDR_LAYOUT_SEPARATE;
        end else begin
            string_count <= strap.string_count;
            layout_kind <= strap.layout_kind;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            switch_freq_khz <= 12'h000;
        end else begin
            switch_freq_khz <= strap.switch_freq_khz;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dim_mode <= bdr_pkg::BDR_DIM_PWM;
            bus_addr <= 7'h00;
        end else begin
            dim_mode <= strap.dim_mode;
            bus_addr <= strap.bus_addr;
        end
    end

    // ----------------------------------------------------------------
    // boost voltage slope term
    // ----------------------------------------------------------------
    // output level is a fixed divider term plus times a per-code current; the resistors
    // sit off-chip, so only the per-code current is formed here, in 0.1 nA units
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boost_step_dna <= 19'h00000;
        end else begin
            // both operands widened first so the product keeps its top bits
            boost_step_dna <= 19'(boost_voltage_code_readback_reg)
                              * 19'(`BDR_BOOST_STEP_DNA);
        end
    end

    // ----------------------------------------------------------------
    // field packing
    // ----------------------------------------------------------------
    // reserved positions start low, so no field can spill into them
    function automatic logic [15:0] pack_strap_word(input logic [2:0] led_freq,
                                                    input logic [2:0] layout,
                                                    input logic [2:0] switch_freq,
                                                    input logic [2:0] mode);
        pack_strap_word = 16'h0000;
        pack_strap_word[`BDR_LED_FREQ_LSB +: 3] = led_freq;
        pack_strap_word[`BDR_LAYOUT_LSB +: 3] = layout;
        pack_strap_word[`BDR_SWITCH_FREQ_LSB +: 3] = switch_freq;
        pack_strap_word[`BDR_MODE_LSB +: 3] = mode;
    endfunction

    function automatic logic [15:0] widen_code(input logic [11:0] code);
        widen_code = {4'h0, code};
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        unique case (addr)
            `BDR_OFS_OUTPUT_DUTY, `BDR_OFS_LED_CURRENT,
            `BDR_OFS_BOOST_VOLTAGE, `BDR_OFS_STRAP_DETECT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    always_comb begin
        rd_data_next = 16'h0000;
        hit_next = is_mapped(reg_addr);
        unique case (reg_addr)
            `BDR_OFS_OUTPUT_DUTY: rd_data_next = output_duty_readback_reg;
            `BDR_OFS_LED_CURRENT: begin
                rd_data_next = widen_code(led_current_code_readback_reg);
            end
            `BDR_OFS_BOOST_VOLTAGE: begin
                rd_data_next = widen_code({1'b0, boost_voltage_code_readback_reg});
            end
            `BDR_OFS_STRAP_DETECT: begin
                rd_data_next = pack_strap_word(led_freq_reg, layout_reg,
                                               switch_freq_reg, mode_reg);
            end
            default: rd_data_next = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rd_valid <= 1'b0;
            reg_addr_hit <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            reg_addr_hit <= (reg_rd_en | reg_wr_en) & hit_next;
        end
    end

    // data holds the last read so a slow host can still pick it up
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rd_data <= 16'h0000;
        end else if (reg_rd_en) begin
            reg_rd_data <= rd_data_next;
        end
    end

endmodule

// ===== bdr_readback_monitor.sv
// assertion checker for the diagnostic readback bank
`timescale 1ns/1ps
module bdr_readback_monitor (
    input logic mclk,
    input logic nrst,
    input logic reg_rd_en,
    input logic [7:0] reg_addr,
    input logic [15:0] reg_rd_data,
    input logic reg_rd_valid,
    input logic reg_addr_hit,
    input logic duty_update,
    input logic [15:0] duty_code,
    input logic dac_update,
    input logic [11:0] sink_dac_code,
    input logic strap_done,
    input logic [2:0] detected_string_layout,
    input logic [2:0] detected_mode_code,
    input logic [2:0] string_count,
    input bdr_pkg::bdr_dim_mode_t dim_mode,
    input logic [6:0] bus_addr,
    input logic boost_update,
    input logic [10:0] boost_level_code,
    input logic [18:0] boost_step_dna
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    read_answer_a: assert property (reg_rd_valid == $past(reg_rd_en))
        else $error("read answer out of step");
    unmapped_read_a: assert property (reg_rd_en && !(reg_addr inside {8'h18, 8'h1A,
        8'h1C, 8'h1E}) |=> reg_rd_data == 16'h0000 && !reg_addr_hit) else $error("unmapped");
    duty_read_a: assert property (duty_update ##1 (reg_rd_en && reg_addr == 8'h18)
        |=> reg_rd_data == $past(duty_code, 2)) else $error("duty readback");
    dac_read_a: assert property (dac_update ##1 (reg_rd_en && reg_addr == 8'h1A)
        |=> reg_rd_data == {4'h0, $past(sink_dac_code, 2)}) else $error("dac readback");
    bus_addr_a: assert property (strap_done |-> ##2 bus_addr ==
        ($past(detected_mode_code, 2) > 3'h3 ? 7'h2A : 7'h2B)) else $error("bus address");
    dim_order_a: assert property (strap_done |-> ##2
        dim_mode == $past(detected_mode_code[1:0], 2)) else $error("dimming mode");
    // 3-bit wrap gives 8 minus code for the grouped layouts
    string_count_a: assert property (strap_done |-> ##2 string_count ==
        (($past(detected_string_layout, 2) < 3'h5 ? 3'h6 : 3'h0) -
        $past(detected_string_layout, 2))) else $error("string count");
    boost_step_a: assert property (boost_update |-> ##2 boost_step_dna ==
        19'($past(boost_level_code, 2)) * 19'h000BD) else $error("boost step");
endmodule

bind bdr_readback_bank bdr_readback_monitor mon (.mclk, .nrst, .reg_rd_en, .reg_addr,
    .reg_rd_data, .reg_rd_valid, .reg_addr_hit, .duty_update, .duty_code, .dac_update,
    .sink_dac_code, .strap_done, .detected_string_layout, .detected_mode_code, .string_count,
    .dim_mode, .bus_addr, .boost_update, .boost_level_code, .boost_step_dna);

// ===== bdr_host_model.sv
// host model issuing single accesses on the register port
`timescale 1ns/1ps
module bdr_host_model (
    input logic mclk,
    input logic [15:0] rd_data,
    input logic addr_hit,
    output logic rd_en,
    output logic wr_en,
    output logic [7:0] addr,
    output logic [15:0] wr_data
);
    initial begin
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 8'hFF;
        wr_data = 16'hFFFF;
    end
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic hit);
        @(negedge mclk);
        rd_en = !wr;
        wr_en = wr;
        addr = a;
        wr_data = d;
        @(negedge mclk);
        // released lines show the complement so a stale copy cannot pass
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = ~a;
        wr_data = ~d;
        q = rd_data;
        hit = addr_hit;
    endtask
endmodule

// ===== backlight_diag_readback_regs_tb_top.sv
// self-checking testbench of the diagnostic readback bank
`timescale 1ns/1ps
module backlight_diag_readback_regs_tb_top;
    logic mclk, nrst, reg_rd_en, reg_wr_en, reg_addr_hit, reg_rd_valid;
    logic [7:0] reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data, duty_code, q;
    logic duty_update, dac_update, boost_update, strap_done, hit;
    logic [11:0] sink_dac_code, switch_freq_khz;
    logic [10:0] boost_level_code;
    logic [2:0] c_led, c_lay, c_sw, c_mode, string_count;
    logic [14:0] led_freq_hz;
    logic [6:0] bus_addr;
    logic [18:0] boost_step_dna;
    bdr_pkg::bdr_layout_kind_t layout_kind;
    bdr_pkg::bdr_dim_mode_t dim_mode;
    int errors = 0;
    int n_compared = 0;
    localparam logic [14:0] LED_HZ [8] = '{15'h0098, 15'h0131, 15'h0262, 15'h04C5,
        15'h0989, 15'h1313, 15'h2626, 15'h4C4B};
    localparam logic [11:0] SW_KHZ [8] = '{12'h064, 12'h0C8, 12'h12F, 12'h190,
        12'h1F4, 12'h71A, 12'h7D0, 12'h8AE};

    bdr_readback_bank dut (.mclk, .nrst, .reg_rd_en, .reg_wr_en, .reg_addr, .reg_wr_data,
        .reg_rd_data, .reg_rd_valid, .reg_addr_hit, .duty_update, .duty_code, .dac_update,
        .sink_dac_code, .boost_update, .boost_level_code, .strap_done,
        .detected_led_freq_code(c_led), .detected_string_layout(c_lay),
        .detected_switch_freq_code(c_sw), .detected_mode_code(c_mode), .led_freq_hz,
        .string_count, .layout_kind, .switch_freq_khz, .dim_mode, .bus_addr, .boost_step_dna);
    bdr_host_model host (.mclk, .rd_data(reg_rd_data), .addr_hit(reg_addr_hit),
        .rd_en(reg_rd_en), .wr_en(reg_wr_en), .addr(reg_addr), .wr_data(reg_wr_data));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // strobe one source, then read at once so the read lands right after capture
    task automatic strobe_read(input int src, input logic [7:0] a);
        @(negedge mclk);
        {duty_update, dac_update, boost_update, strap_done} = 4'h8 >> src;
        fork
            host.access(1'b0, a, 16'h0000, q, hit);
            begin
                @(negedge mclk);
                {duty_update, dac_update, boost_update, strap_done} = 4'h0;
            end
        join
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            host.access(1'b0, 8'h18 + 8'(2 * i), 16'h0000, q, hit);
            check(q, 32'h0);
            check(hit, i < 4);
        end
    endtask
    task automatic t_duty_write();
        duty_code = 16'hA5C3;
        strobe_read(0, 8'h18);
        check(q, 32'hA5C3);
        host.access(1'b1, 8'h18, 16'h5A3C, q, hit);
        check(hit, 32'h1);
        host.access(1'b0, 8'h18, 16'h0000, q, hit);
        check(q, 32'hA5C3);
    endtask
    task automatic t_dac_boost();
        sink_dac_code = 12'hFFF;
        strobe_read(1, 8'h1A);
        check(q, 32'h0FFF);
        boost_level_code = 11'h7FF;
        strobe_read(2, 8'h1C);
        check(q, 32'h07FF);
        check(boost_step_dna, 32'h7FF * 32'hBD);
    endtask
    task automatic t_strap();
        for (int k = 0; k < 8; k++) begin
            c_led = 3'(k);
            c_lay = 3'(7 - k);
            c_sw = 3'(k + 3);
            c_mode = 3'(k);
            strobe_read(3, 8'h1E);
            check(q, {1'b0, c_led, 1'b0, c_lay, 2'b00, c_sw, c_mode});
            check(led_freq_hz, LED_HZ[k]);
            check(string_count, (c_lay < 3'h5 ? 32'h6 : 32'h8) - c_lay);
            check(layout_kind, c_lay < 3'h5 ? 32'h0 : c_lay - 32'h4);
            check(switch_freq_khz, SW_KHZ[c_sw]);
            check(bus_addr, k > 3 ? 32'h2A : 32'h2B);
            check(dim_mode, k % 4);
        end
    endtask
    initial begin
        nrst = 1'b0;
        {duty_update, dac_update, boost_update, strap_done} = 4'h0;
        {duty_code, sink_dac_code, boost_level_code} = 39'h0;
        {c_led, c_lay, c_sw, c_mode} = 12'h000;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        t_reset();
        t_duty_write();
        t_dac_boost();
        t_strap();
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge mclk);
        errors++;
        report_and_stop();
    end
endmodule
